// ### src/csr_core_regs.sv
// Special register set of the 8-bit core: operand registers, status word,
// stack pointer, dual data pointers, auxiliary and interface control.
// Assumes the core's internal register port and one clock with sync reset.
`timescale 1ns/10ps
`default_nettype none
`include "csr_params.svh"
module csr_core_regs (
    // Clock and reset
    input  wire logic               i_clock,
    input  wire logic               i_rst,
    // Internal register port
    input  wire csr_pkg::csr_byte_t i_sfr_addr,
    input  wire logic               i_sfr_wr,
    input  wire logic               i_sfr_rd,
    input  wire csr_pkg::csr_byte_t i_sfr_wdata,
    output var  csr_pkg::csr_byte_t o_sfr_rdata,
    output var  logic               o_sfr_hit,
    // Main and second operand results
    input  wire logic               i_acc_we,
    input  wire csr_pkg::csr_byte_t i_acc_wdata,
    input  wire logic               i_b_we,
    input  wire csr_pkg::csr_byte_t i_b_wdata,
    // Arithmetic flag results
    input  wire logic               i_cy_we,
    input  wire logic               i_cy,
    input  wire logic               i_ac_we,
    input  wire logic               i_ac,
    input  wire logic               i_ov_we,
    input  wire logic               i_ov,
    // Stack operations
    input  wire logic               i_push,
    input  wire logic               i_pop,
    // Data pointer operations
    input  wire logic               i_data_pointer_pair_load,
    input  wire csr_pkg::csr_word_t i_data_pointer_pair_data,
    input  wire logic               i_data_pointer_pair_inc,
    // External access and protection status
    input  wire logic               i_ext_access,
    input  wire logic               i_code_protect,
    // Register state towards the core
    output var  csr_pkg::csr_byte_t o_acc,
    output var  csr_pkg::csr_byte_t o_b,
    output var  csr_pkg::csr_byte_t o_psw,
    output var  logic               o_parity,
    output var  logic [4:0]         o_bank_base,
    output var  csr_pkg::csr_byte_t o_stack_ptr,
    output var  csr_pkg::csr_word_t o_data_pointer_pair,
    output var  logic               o_data_pointer_pair_sel,
    // Control outputs
    output var  logic               o_one_clock_mode,
    output var  logic               o_latch_strobe_en,
    output var  logic               o_isp_enable,
    output var  logic               o_baud_gen_sel,
    output var  logic               o_port1_uart_route
);
    import csr_pkg::*;

    // -----------------------------------------------------------------
    // Address decode
    // -----------------------------------------------------------------
    logic wr_sp;
    logic wr_p0lo;
    logic wr_p0hi;
    logic wr_p1lo;
    logic wr_p1hi;
    logic wr_interface_control;
    logic wr_aux;
    logic wr_psw;
    logic wr_acc;
    logic wr_b;
    logic addr_hit;

    always_comb begin
        wr_sp    = i_sfr_wr && (i_sfr_addr == `CSR_ADDR_SP);
        wr_p0lo  = i_sfr_wr && (i_sfr_addr == `CSR_ADDR_P0LO);
        wr_p0hi  = i_sfr_wr && (i_sfr_addr == `CSR_ADDR_P0HI);
        wr_p1lo  = i_sfr_wr && (i_sfr_addr == `CSR_ADDR_P1LO);
        wr_p1hi  = i_sfr_wr && (i_sfr_addr == `CSR_ADDR_P1HI);
        wr_interface_control = i_sfr_wr && (i_sfr_addr == `CSR_ADDR_INTERFACE_CONTROL);
        wr_aux   = i_sfr_wr && (i_sfr_addr == `CSR_ADDR_AUX);
        wr_psw   = i_sfr_wr && (i_sfr_addr == `CSR_ADDR_PSW);
        wr_acc   = i_sfr_wr && (i_sfr_addr == `CSR_ADDR_ACC);
        wr_b     = i_sfr_wr && (i_sfr_addr == `CSR_ADDR_B);
    end

    always_comb begin
        unique case (i_sfr_addr)
            `CSR_ADDR_SP, `CSR_ADDR_P0LO, `CSR_ADDR_P0HI,
            `CSR_ADDR_P1LO, `CSR_ADDR_P1HI, `CSR_ADDR_INTERFACE_CONTROL,
            `CSR_ADDR_AUX, `CSR_ADDR_PSW, `CSR_ADDR_ACC,
            `CSR_ADDR_B: begin
                addr_hit = 1'b1;
            end
            default: begin
                addr_hit = 1'b0;
            end
        endcase
    end

    // -----------------------------------------------------------------
    // Main operand register
    // -----------------------------------------------------------------
    csr_byte_t next_acc;

    // Instruction result takes priority over a register-port write
    always_comb begin
        next_acc = o_acc;
        if (i_acc_we) begin
            next_acc = i_acc_wdata;
        end else if (wr_acc) begin
            next_acc = i_sfr_wdata;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_acc <= `CSR_RST_BYTE;
        end else begin
            o_acc <= next_acc;
        end
    end

    // -----------------------------------------------------------------
    // Second operand register
    // -----------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_b <= `CSR_RST_BYTE;
        end else if (i_b_we) begin
            o_b <= i_b_wdata;
        end else if (wr_b) begin
            o_b <= i_sfr_wdata;
        end
    end

    // -----------------------------------------------------------------
    // Program status word
    // -----------------------------------------------------------------
    csr_byte_t next_psw;

    always_comb begin
        next_psw = o_psw;
        if (wr_psw) begin
            // User flags, bank select and arithmetic flags store writes
            next_psw = (i_sfr_wdata & `CSR_PSW_WMASK)
                     | (o_psw & ~`CSR_PSW_WMASK);
        end
        if (i_cy_we) begin
            next_psw[`CSR_PSW_CY] = i_cy;
        end
        if (i_ac_we) begin
            next_psw[`CSR_PSW_AC] = i_ac;
        end
        if (i_ov_we) begin
            next_psw[`CSR_PSW_OV] = i_ov;
        end
        // Bit plus operand ones make an even count
        next_psw[`CSR_PSW_P] = ^next_acc;
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_psw <= `CSR_RST_BYTE;
        end else begin
            o_psw <= next_psw;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_parity <= 1'b0;
        end else begin
            o_parity <= ^next_acc;
        end
    end

    // Working bank base address in internal RAM
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_bank_base <= 5'h00;
        end else begin
            o_bank_base <= {next_psw[`CSR_PSW_RS_HI:`CSR_PSW_RS_LO],
                            3'h0};
        end
    end

    // -----------------------------------------------------------------
    // Stack pointer
    // -----------------------------------------------------------------
    csr_stack u_stack (
        .i_clock (i_clock),
        .i_rst   (i_rst),
        .i_wr    (wr_sp),
        .i_wdata (i_sfr_wdata),
        .i_push  (i_push),
        .i_pop   (i_pop),
        .o_ptr   (o_stack_ptr)
    );

    // -----------------------------------------------------------------
    // Data pointers
    // -----------------------------------------------------------------
    csr_word_t ptr_q [2];

    csr_data_pointer_pair #(
        .N_PTR (2)
    ) u_data_pointer_pair (
        .i_clock     (i_clock),
        .i_rst       (i_rst),
        .i_lo_we     ({wr_p1lo, wr_p0lo}),
        .i_hi_we     ({wr_p1hi, wr_p0hi}),
        .i_wdata     (i_sfr_wdata),
        .i_sel_we    (wr_aux),
        .i_sel_wdata (i_sfr_wdata[`CSR_AUX_DPS]),
        .i_load      (i_data_pointer_pair_load),
        .i_load_data (i_data_pointer_pair_data),
        .i_inc       (i_data_pointer_pair_inc),
        .o_ptr       (ptr_q),
        .o_sel       (o_data_pointer_pair_sel),
        .o_active    (o_data_pointer_pair)
    );

    // -----------------------------------------------------------------
    // Auxiliary register
    // -----------------------------------------------------------------
    // Only the baud generator select and UART routing bits are held here; the pointer select is in u_data_pointer_pair
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_baud_gen_sel     <= 1'b0;
            o_port1_uart_route <= 1'b0;
        end else if (wr_aux) begin
            o_baud_gen_sel     <= i_sfr_wdata[`CSR_AUX_BRGS];
            o_port1_uart_route <= i_sfr_wdata[`CSR_AUX_P1UR];
        end
    end

    // -----------------------------------------------------------------
    // Interface control register
    // -----------------------------------------------------------------
    csr_latch_mode_t latch_mode;
    logic            code_protect;

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_one_clock_mode <= 1'b0;
            latch_mode       <= CSR_LATCH_ALWAYS;
            o_isp_enable     <= 1'b0;
        end else if (wr_interface_control) begin
            o_one_clock_mode <= i_sfr_wdata[`CSR_IFC_ITS];
            latch_mode       <= csr_latch_mode_t'(
                i_sfr_wdata[`CSR_IFC_ALE_HI:`CSR_IFC_ALE_LO]);
            o_isp_enable     <= i_sfr_wdata[`CSR_IFC_IN_SYSTEM_PROG_ENABLE];
        end
    end

    // Protection status follows the flash state only, never the bus
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            code_protect <= 1'b0;
        end else begin
            code_protect <= i_code_protect;
        end
    end

    // Address latch strobe enable
    logic next_strobe_en;

    always_comb begin
        unique case (latch_mode)
            CSR_LATCH_ALWAYS: begin
                next_strobe_en = 1'b1;
            end
            CSR_LATCH_NEVER: begin
                next_strobe_en = 1'b0;
            end
            CSR_LATCH_EXT: begin
                next_strobe_en = i_ext_access;
            end
            CSR_LATCH_RSVD: begin
                next_strobe_en = 1'b1;
            end
        endcase
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_latch_strobe_en <= 1'b1;
        end else begin
            o_latch_strobe_en <= next_strobe_en;
        end
    end

    // -----------------------------------------------------------------
    // Read data
    // -----------------------------------------------------------------
    csr_byte_t next_rdata;
    csr_byte_t interface_control_view;
    csr_byte_t aux_view;

    always_comb begin
        interface_control_view = 8'h00;
        interface_control_view[`CSR_IFC_ITS]  = o_one_clock_mode;
        interface_control_view[`CSR_IFC_CODE_PROTECT_FLAG] = code_protect;
        interface_control_view[`CSR_IFC_ALE_HI:`CSR_IFC_ALE_LO] = latch_mode;
        interface_control_view[`CSR_IFC_IN_SYSTEM_PROG_ENABLE] = o_isp_enable;
        aux_view = 8'h00;
        aux_view[`CSR_AUX_BRGS] = o_baud_gen_sel;
        aux_view[`CSR_AUX_P1UR] = o_port1_uart_route;
        aux_view[`CSR_AUX_DPS]  = o_data_pointer_pair_sel;
    end

    always_comb begin
        unique case (i_sfr_addr)
            `CSR_ADDR_SP: begin
                next_rdata = o_stack_ptr;
            end
            `CSR_ADDR_P0LO: begin
                next_rdata = ptr_q[0][7:0];
            end
            `CSR_ADDR_P0HI: begin
                next_rdata = ptr_q[0][15:8];
            end
            `CSR_ADDR_P1LO: begin
                next_rdata = ptr_q[1][7:0];
            end
            `CSR_ADDR_P1HI: begin
                next_rdata = ptr_q[1][15:8];
            end
            `CSR_ADDR_INTERFACE_CONTROL: begin
                next_rdata = interface_control_view;
            end
            `CSR_ADDR_AUX: begin
                next_rdata = aux_view;
            end
            `CSR_ADDR_PSW: begin
                next_rdata = o_psw;
            end
            `CSR_ADDR_ACC: begin
                next_rdata = o_acc;
            end
            `CSR_ADDR_B: begin
                next_rdata = o_b;
            end
            default: begin
                next_rdata = 8'h00;
            end
        endcase
    end

    // Read answer one cycle after the strobe; held until the next read
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_sfr_rdata <= 8'h00;
            o_sfr_hit   <= 1'b0;
        end else if (i_sfr_rd) begin
            o_sfr_rdata <= next_rdata;
            o_sfr_hit   <= addr_hit;
        end
    end
endmodule : csr_core_regs
`default_nettype wire

// ### src/csr_data_pointer_pair.sv
// Two 16-bit data pointers and the select bit that picks one.
// Assumes byte writes are decoded by the parent from the register bus.
`timescale 1ns/10ps
`default_nettype none
`include "csr_params.svh"
module csr_data_pointer_pair #(
    parameter int N_PTR = 2
) (
    // Clock and reset
    input  wire logic          i_clock,
    input  wire logic          i_rst,
    // Byte writes, low then high per pointer
    input  wire logic [N_PTR-1:0] i_lo_we,
    input  wire logic [N_PTR-1:0] i_hi_we,
    input  wire csr_pkg::csr_byte_t i_wdata,
    // Select bit write
    input  wire logic          i_sel_we,
    input  wire logic          i_sel_wdata,
    // Operations on the active pointer
    input  wire logic          i_load,
    input  wire csr_pkg::csr_word_t i_load_data,
    input  wire logic          i_inc,
    // State
    output var  csr_pkg::csr_word_t o_ptr [N_PTR],
    output var  logic          o_sel,
    output var  csr_pkg::csr_word_t o_active
);
    import csr_pkg::*;

    csr_word_t next_ptr [N_PTR];
    logic      next_sel;

    always_comb begin
        next_sel = i_sel_we ? i_sel_wdata : o_sel;
    end

    for (genvar g = 0; g < N_PTR; g++) begin : g_ptr
        always_comb begin
            next_ptr[g] = o_ptr[g];
            if (i_lo_we[g]) begin
                next_ptr[g][7:0] = i_wdata;
            end
            if (i_hi_we[g]) begin
                next_ptr[g][15:8] = i_wdata;
            end
            if (!i_lo_we[g] && !i_hi_we[g] && (32'(o_sel) == g)) begin
                if (i_load) begin
                    next_ptr[g] = i_load_data;
                end else if (i_inc) begin
                    next_ptr[g] = o_ptr[g] + 16'h0001;
                end
            end
        end

        always_ff @(posedge i_clock) begin
            if (i_rst) begin
                o_ptr[g] <= `CSR_RST_PTR;
            end else begin
                o_ptr[g] <= next_ptr[g];
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_sel    <= 1'b0;
            o_active <= `CSR_RST_PTR;
        end else begin
            o_sel    <= next_sel;
            o_active <= next_ptr[next_sel];
        end
    end
endmodule : csr_data_pointer_pair
`default_nettype wire

// ### src/csr_params.svh
// Offsets, field positions and reset values of the core special registers.
// Assumes inclusion by bare name from every file that decodes registers.
`ifndef CSR_PARAMS_SVH
`define CSR_PARAMS_SVH

// ---------------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------------
`define CSR_ADDR_SP      8'h81
`define CSR_ADDR_P0LO    8'h82
`define CSR_ADDR_P0HI    8'h83
`define CSR_ADDR_P1LO    8'h84
`define CSR_ADDR_P1HI    8'h85
`define CSR_ADDR_INTERFACE_CONTROL   8'h8f
`define CSR_ADDR_AUX     8'h91
`define CSR_ADDR_PSW     8'hd0
`define CSR_ADDR_ACC     8'he0
`define CSR_ADDR_B       8'hf0

// ---------------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------------
`define CSR_RST_SP       8'h07
`define CSR_RST_BYTE     8'h00
`define CSR_RST_PTR      16'h0000

// ---------------------------------------------------------------------
// Field positions and writable masks
// ---------------------------------------------------------------------
`define CSR_PSW_CY       7
`define CSR_PSW_AC       6
`define CSR_PSW_RS_HI    4
`define CSR_PSW_RS_LO    3
`define CSR_PSW_OV       2
`define CSR_PSW_P        0
`define CSR_PSW_WMASK    8'hfe
`define CSR_IFC_ITS      7
`define CSR_IFC_CODE_PROTECT_FLAG     6
`define CSR_IFC_ALE_HI   3
`define CSR_IFC_ALE_LO   2
`define CSR_IFC_IN_SYSTEM_PROG_ENABLE     0
`define CSR_IFC_WMASK    8'h8d
`define CSR_AUX_BRGS     7
`define CSR_AUX_P1UR     4
`define CSR_AUX_DPS      0
`define CSR_AUX_WMASK    8'h91

`endif

// ### src/csr_pkg.sv
// Types shared by the core special register files.
// Assumes nothing of its surroundings.
package csr_pkg;
    typedef logic [7:0]  csr_byte_t;
    typedef logic [15:0] csr_word_t;
    typedef enum logic [1:0] {
        CSR_LATCH_ALWAYS = 2'b00,
        CSR_LATCH_NEVER  = 2'b01,
        CSR_LATCH_EXT    = 2'b10,
        CSR_LATCH_RSVD   = 2'b11
    } csr_latch_mode_t;
endpackage : csr_pkg

// ### src/csr_stack.sv
// Stack pointer with pre-increment push and post-decrement pop.
// Assumes push and pop pulses come from the core sequencer.
`timescale 1ns/10ps
`default_nettype none
`include "csr_params.svh"
module csr_stack (
    // Clock and reset
    input  wire logic          i_clock,
    input  wire logic          i_rst,
    // Register write
    input  wire logic          i_wr,
    input  wire csr_pkg::csr_byte_t i_wdata,
    // Stack operations
    input  wire logic          i_push,
    input  wire logic          i_pop,
    // Top of stack
    output var  csr_pkg::csr_byte_t o_ptr
);
    import csr_pkg::*;

    csr_byte_t next_ptr;

    always_comb begin
        next_ptr = o_ptr;
        if (i_wr) begin
            next_ptr = i_wdata;
        end else if (i_push && !i_pop) begin
            next_ptr = o_ptr + 8'h01;
        end else if (i_pop && !i_push) begin
            next_ptr = o_ptr - 8'h01;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_ptr <= `CSR_RST_SP;
        end else begin
            o_ptr <= next_ptr;
        end
    end
endmodule : csr_stack
`default_nettype wire

// ### testbench/csr_core_regs_sva.sv
// Concurrent checks for the core special register set.
// Assumes a bind onto csr_core_regs, one clock and a sync reset.
`timescale 1ns/10ps
`default_nettype none
module csr_core_regs_sva (
    // Clock and reset
    input wire logic               i_clock,
    input wire logic               i_rst,
    // Register port
    input wire csr_pkg::csr_byte_t i_sfr_addr,
    input wire logic               i_sfr_wr,
    input wire logic               i_sfr_rd,
    input wire csr_pkg::csr_byte_t i_sfr_wdata,
    input wire csr_pkg::csr_byte_t o_sfr_rdata,
    input wire logic               o_sfr_hit,
    // Core operations
    input wire logic               i_acc_we,
    input wire csr_pkg::csr_byte_t i_acc_wdata,
    input wire logic               i_push,
    input wire logic               i_pop,
    input wire logic               i_data_pointer_pair_load,
    input wire csr_pkg::csr_word_t i_data_pointer_pair_data,
    input wire logic               i_data_pointer_pair_inc,
    // Register state
    input wire csr_pkg::csr_byte_t o_acc,
    input wire csr_pkg::csr_byte_t o_psw,
    input wire logic               o_parity,
    input wire logic [4:0]         o_bank_base,
    input wire csr_pkg::csr_byte_t o_stack_ptr,
    input wire csr_pkg::csr_word_t o_data_pointer_pair,
    input wire logic               o_one_clock_mode,
    input wire logic               o_latch_strobe_en
);
    import csr_pkg::*;
    logic stk_wr;
    logic ctl_wr;
    assign stk_wr = i_sfr_wr && i_sfr_addr == 8'h81;
    assign ctl_wr = i_sfr_wr && i_sfr_addr == 8'h8f;
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);

    a_parity_even: assert property (o_parity == ^o_acc && o_psw[0] == o_parity)
        else $error("parity bit does not match main operand");
    a_bank_map: assert property (o_bank_base == {o_psw[4:3], 3'b000})
        else $error("bank base does not match bank select");
    a_reset_vals: assert property ($fell(i_rst) |-> o_stack_ptr == 8'h07 && !o_one_clock_mode)
        else $error("wrong value after reset");
    a_push_inc: assert property (i_push && !i_pop && !stk_wr |=> o_stack_ptr == $past(o_stack_ptr) + 8'h01)
        else $error("push did not pre-increment");
    a_pop_dec: assert property (i_pop && !i_push && !stk_wr |=> o_stack_ptr == $past(o_stack_ptr) - 8'h01)
        else $error("pop did not decrement");
    a_ptr_load: assert property (i_data_pointer_pair_load && !i_sfr_wr |=> o_data_pointer_pair == $past(i_data_pointer_pair_data))
        else $error("pointer load lost");
    a_ptr_inc: assert property (i_data_pointer_pair_inc && !i_data_pointer_pair_load && !i_sfr_wr |=> o_data_pointer_pair == $past(o_data_pointer_pair) + 16'h0001)
        else $error("pointer increment wrong");
    a_stack_read: assert property (i_sfr_rd && i_sfr_addr == 8'h81 |=> o_sfr_hit && o_sfr_rdata == $past(o_stack_ptr))
        else $error("stack read wrong");
    a_unused_zero: assert property (i_sfr_rd && i_sfr_addr == 8'h8f |=> o_sfr_rdata[5:4] == 2'b00 && !o_sfr_rdata[1])
        else $error("unused control bits not zero");
    a_latch_never: assert property (ctl_wr && i_sfr_wdata[3:2] == 2'b01 |=> ##1 !o_latch_strobe_en)
        else $error("strobe on in never mode");
    a_main_update: assert property (i_acc_we |=> o_acc == $past(i_acc_wdata))
        else $error("main operand update lost");
    a_timing_sel: assert property (ctl_wr |=> o_one_clock_mode == $past(i_sfr_wdata[7]))
        else $error("timing select wrong");
    a_user_flags: assert property (!(i_sfr_wr && i_sfr_addr == 8'hd0) |=> $stable(o_psw[5]) && $stable(o_psw[1]))
        else $error("user flag changed without write");
endmodule : csr_core_regs_sva

bind csr_core_regs csr_core_regs_sva u_sva (.*);
`default_nettype wire

// ### testbench/csr_core_regs_test.sv
// Self-checking bench for the core special register set.
// Assumes the design files and the checker are compiled first.
`timescale 1ns/10ps
`default_nettype none
module csr_core_regs_test;
    import csr_pkg::*;
    logic      i_clock, i_rst, i_sfr_wr, i_sfr_rd, i_push, i_pop;
    logic      i_acc_we, i_b_we, i_cy_we, i_ac_we, i_ov_we, i_cy, i_ac, i_ov;
    logic      i_data_pointer_pair_load, i_data_pointer_pair_inc, i_ext_access, i_code_protect;
    csr_byte_t i_sfr_addr, i_sfr_wdata, i_acc_wdata, i_b_wdata;
    csr_word_t i_data_pointer_pair_data, o_data_pointer_pair;
    csr_byte_t o_sfr_rdata, o_acc, o_b, o_psw, o_stack_ptr;
    logic      o_sfr_hit, o_parity, o_data_pointer_pair_sel, o_one_clock_mode;
    logic      o_latch_strobe_en, o_isp_enable, o_baud_gen_sel;
    logic      o_port1_uart_route;
    logic [4:0] o_bank_base;
    int        bad_count, total_checks;
    localparam csr_byte_t MAP [10] = '{8'h81, 8'h82, 8'h83, 8'h84, 8'h85,
                                       8'h8f, 8'h91, 8'hd0, 8'he0, 8'hf0};
    csr_core_regs u_dut (.*);

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input csr_byte_t a, input csr_byte_t d);
        @(posedge i_clock);
        i_sfr_addr  <= a;
        i_sfr_wdata <= d;
        i_sfr_wr    <= 1'b1;
        @(posedge i_clock);
        i_sfr_wr <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input csr_byte_t a, input csr_byte_t e, input logic h);
        @(posedge i_clock);
        i_sfr_addr <= a;
        i_sfr_rd   <= 1'b1;
        @(posedge i_clock);
        i_sfr_rd <= 1'b0;
        @(posedge i_clock);
        #1;
        chk(o_sfr_rdata, e);
        chk(o_sfr_hit, h);
    endtask : rd
    // Strobes: push pop load inc main second carry half range
    task automatic core(input logic [8:0] k, input csr_byte_t d,
                        input csr_word_t w);
        @(posedge i_clock);
        {i_push, i_pop, i_data_pointer_pair_load, i_data_pointer_pair_inc, i_acc_we} <= k[8:4];
        {i_b_we, i_cy_we, i_ac_we, i_ov_we} <= k[3:0];
        {i_acc_wdata, i_b_wdata, i_data_pointer_pair_data} <= {d, d, w};
        {i_cy, i_ac, i_ov} <= {3{d[0]}};
        @(posedge i_clock);
        {i_push, i_pop, i_data_pointer_pair_load, i_data_pointer_pair_inc, i_acc_we} <= 5'h00;
        {i_b_we, i_cy_we, i_ac_we, i_ov_we} <= 4'h0;
        #1;
    endtask : core

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        chk(o_latch_strobe_en, 1'b1);
        for (int i = 0; i < 10; i++)
            rd(MAP[i], (i == 0) ? 8'h07 : 8'h00, 1'b1);
        rd(8'h80, 8'h00, 1'b0);
    endtask : t_reset
    task automatic t_bank();
        for (int k = 0; k < 4; k++) begin
            wr(8'hd0, 8'(k << 3));
            chk(o_bank_base, 16'(k * 8));
        end
        wr(8'hd0, 8'hff);
        rd(8'hd0, 8'hfe, 1'b1);
        wr(8'hd0, 8'h00);
    endtask : t_bank
    task automatic t_parity();
        csr_byte_t v [6] = '{8'h01, 8'h03, 8'h80, 8'hff, 8'h7f, 8'h00};
        for (int i = 0; i < 6; i++) begin
            core(9'h010, v[i], 16'h0000);
            chk(o_acc, v[i]);
            chk({o_parity, o_psw[0]}, {2{^v[i]}});
        end
        wr(8'he0, 8'h07);
        chk(o_parity, 1'b1);
    endtask : t_parity
    task automatic t_stack();
        core(9'h100, 8'h00, 16'h0000);
        chk(o_stack_ptr, 8'h08);
        core(9'h100, 8'h00, 16'h0000);
        core(9'h080, 8'h00, 16'h0000);
        chk(o_stack_ptr, 8'h08);
        core(9'h180, 8'h00, 16'h0000);
        rd(8'h81, 8'h08, 1'b1);
    endtask : t_stack
    task automatic t_ptr();
        for (int i = 0; i < 4; i++)
            wr(8'(8'h82 + i), 8'(8'h11 * (i + 1)));
        chk({o_data_pointer_pair_sel, o_data_pointer_pair}, 17'h02211);
        wr(8'h91, 8'h01);
        chk({o_data_pointer_pair_sel, o_data_pointer_pair}, 17'h14433);
        core(9'h040, 8'h00, 16'h1234);
        core(9'h020, 8'h00, 16'h0000);
        chk(o_data_pointer_pair, 16'h1235);
        rd(8'h82, 8'h11, 1'b1);
        rd(8'h85, 8'h12, 1'b1);
        wr(8'h91, 8'hff);
        rd(8'h91, 8'h91, 1'b1);
        chk({o_baud_gen_sel, o_port1_uart_route}, 2'b11);
        wr(8'h91, 8'h00);
        chk(o_data_pointer_pair, 16'h2211);
    endtask : t_ptr
    task automatic t_ctrl();
        wr(8'h8f, 8'hff);
        rd(8'h8f, 8'h8d, 1'b1);
        chk({o_one_clock_mode, o_isp_enable}, 2'b11);
        @(posedge i_clock);
        i_code_protect <= 1'b1;
        wr(8'h8f, 8'h00);
        rd(8'h8f, 8'h40, 1'b1);
        chk({o_one_clock_mode, o_isp_enable}, 2'b00);
        for (int m = 0; m < 8; m++) begin
            @(posedge i_clock);
            i_ext_access <= m[0];
            wr(8'h8f, {4'h0, m[2:1], 2'h0});
            @(posedge i_clock);
            #1;
            chk(o_latch_strobe_en, (m[2:1] == 2'b01) ? 1'b0 :
                (m[2:1] == 2'b10) ? m[0] : 1'b1);
        end
    endtask : t_ctrl
    task automatic t_ops();
        core(9'h007, 8'h01, 16'h0000);
        chk({o_psw[7:6], o_psw[2]}, 3'b111);
        core(9'h007, 8'h00, 16'h0000);
        chk({o_psw[7:6], o_psw[2]}, 3'b000);
        core(9'h008, 8'h5a, 16'h0000);
        chk(o_b, 8'h5a);
        wr(8'hf0, 8'ha5);
        rd(8'hf0, 8'ha5, 1'b1);
    endtask : t_ops

    // ------------------------------------------------------------------
    // Run control
    // ------------------------------------------------------------------
    task automatic print_verdict();
        if (bad_count == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : print_verdict
    initial begin
        i_clock = 1'b0;
        forever #2.5 i_clock = ~i_clock;
    end
    initial begin
        repeat (4000) @(posedge i_clock);
        bad_count++;
        print_verdict();
    end
    initial begin
        {i_rst, i_sfr_wr, i_sfr_rd, i_push, i_pop, i_acc_we, i_b_we} = 7'h40;
        {i_cy_we, i_ac_we, i_ov_we, i_cy, i_ac, i_ov} = 6'h00;
        {i_data_pointer_pair_load, i_data_pointer_pair_inc, i_ext_access, i_code_protect} = 4'h0;
        {i_sfr_addr, i_sfr_wdata, i_acc_wdata, i_b_wdata} = 32'h0;
        i_data_pointer_pair_data = 16'h0000;
        i_rst = 1'b1;
        repeat (20) @(posedge i_clock);
        i_rst <= 1'b0;
        @(posedge i_clock);
        #1;
        t_reset();
        t_bank();
        t_parity();
        t_stack();
        t_ptr();
        t_ctrl();
        t_ops();
        print_verdict();
    end
endmodule : csr_core_regs_test
`default_nettype wire
